// file: common/adr_pkg.sv
// shared constants for the biphase-mark state recovery unit
package adr_pkg;
  // ---------------------------------------------------------------
  // widths and timing
  // ---------------------------------------------------------------
  localparam int unsigned CNT_W        = 8;
  localparam int unsigned FIFO_DEPTH   = 8;
  localparam int unsigned FIFO_W       = 1;
  localparam int unsigned REF_CLK_HZ   = 20_000_000;
  localparam int unsigned REF_CLK_NS   = 50;
  // minimum-width tracker: forget the held minimum after one more than this many states
  localparam logic [7:0]  MIN_AGE_MAX  = 8'hFF;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] MIN_RST = 8'hFF;
  localparam logic [7:0]  AGE_RST      = 8'h00;
endpackage : adr_pkg

// file: common/adr_stream_if.sv
// valid/ready stream carrying recovered states between modules
interface adr_stream_if #(parameter int unsigned W = 1);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src  (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : adr_stream_if

// file: logic/adr_fifo.sv
// small synchronous fifo with valid/ready on both sides
module adr_fifo #(
  parameter int unsigned W     = 1,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  // ports
  adr_stream_if.sink      wr,
  adr_stream_if.src       rd
);
  import adr_pkg::*;
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push, pop;

  assign wr.ready = (cnt_r != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_r != '0);
  assign rd.data  = mem[rp_r];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  always_comb begin
    wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
    rp_nxt  = pop  ? AW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = (AW+1)'(cnt_r + 1'b1);
    end else if (pop && !push) begin
      cnt_nxt = (AW+1)'(cnt_r - 1'b1);
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage carries no reset: only entries counted by cnt_r are read
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wp_r] <= wr.data;
    end
  end

  AST_FIFO_NO_OVER : assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    cnt_r <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : adr_fifo

// file: logic/adr_recovery.sv
// oversampling biphase-mark state recovery unit (top)
// Contract
// - the unit counts local clock cycles in the narrowest state seen on the serial input.
// - it samples each state near its middle using half the measured narrowest width.
// - the narrowest width is measured without end, so it follows sample rate changes.
// - each valid strobe carries exactly one recovered biphase-mark state, not a decoded bit.
// - the strobe rate follows the audio rate, 128 per audio sample, at most one every two cycles of the 20 MHz clock.
// - recovery is purely digital oversampling, needing no external phase-locked loop.
// - the full receiver chains this unit, a framer, a formatter, output registers and demux.
// - recovered states and their strobes go on to the framer, which finds the preambles.
// - reset acts asynchronously and returns all recovery registers to their reset values (widths to all ones); fifo storage is not reset.
module adr_recovery
  import adr_pkg::*;
#(
  parameter int unsigned CW    = adr_pkg::CNT_W,
  parameter int unsigned DEPTH = adr_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  // serial input
  input  wire logic serial_i,
  // recovered state stream toward the framer
  input  wire logic framer_ready_i,
  output logic      state_o,
  output logic      data_valid_o,
  output logic      in_ready_o,
  // measurement status
  output logic [CW-1:0] min_width_o
);
  import adr_pkg::*;

  typedef enum logic [0:0] {ADR_IDLE, ADR_RUN} adr_state_t;

  // ---------------------------------------------------------------
  // input edge detection and width measurement
  // ---------------------------------------------------------------
  logic          din_r, din_nxt;
  logic [CW-1:0] run_r, run_nxt;      // cycles since last transition
  logic [CW-1:0] min_r, min_nxt;      // narrowest state seen
  logic [CW-1:0] cand_r, cand_nxt;    // narrowest state within the current window
  logic [7:0]    age_r, age_nxt;      // states since min last refreshed
  logic [CW-1:0] pos_r, pos_nxt;      // position within current state slot
  adr_state_t    st_r, st_nxt;
  logic          edge_det, take;
  logic [CW-1:0] half;

  adr_stream_if #(.W(FIFO_W)) fin ();
  adr_stream_if #(.W(FIFO_W)) fout ();

  assign edge_det = (serial_i != din_r);
  assign half     = CW'(min_r >> 1);

  always_comb begin
    din_nxt = serial_i;
    run_nxt = edge_det ? CNT_ONE : ((run_r == CNT_MAX) ? run_r : CW'(run_r + 1'b1));
    min_nxt  = min_r;
    cand_nxt = cand_r;
    age_nxt  = age_r;
    st_nxt   = st_r;
    pos_nxt  = CW'(pos_r + 1'b1);
    take     = 1'b0;
    // a narrower state wins at once; otherwise the window minimum replaces the held one,
    // so a slower rate is followed without a lone long state inflating the width
    if (edge_det) begin
      if (run_r < min_r) begin
        min_nxt  = run_r;
        age_nxt  = AGE_RST;
        cand_nxt = CNT_MAX;
      end else if (age_r == MIN_AGE_MAX) begin
        min_nxt  = (run_r < cand_r) ? run_r : cand_r;
        age_nxt  = AGE_RST;
        cand_nxt = CNT_MAX;
      end else begin
        age_nxt  = 8'(age_r + 1'b1);
        cand_nxt = (run_r < cand_r) ? run_r : cand_r;
      end
    end
    case (st_r)
      ADR_IDLE: begin
        pos_nxt = '0;
        if (edge_det) begin
          st_nxt  = ADR_RUN;
          pos_nxt = CNT_ONE;
        end
      end
      ADR_RUN: begin
        // resync the slot on every edge; long states yield one take per min width
        if (edge_det) begin
          pos_nxt = CNT_ONE;
        end else if (pos_r == half) begin
          take = 1'b1;
        end else if (pos_r >= CW'(min_r - 1'b1)) begin
          pos_nxt = '0;
        end
      end
      default: begin
        st_nxt  = ADR_IDLE;
        pos_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      din_r  <= 1'b0;
      // saturated width: an edge right after reset is not taken as a narrow state
      run_r  <= CNT_MAX;
      min_r  <= MIN_RST;
      cand_r <= MIN_RST;
      age_r  <= AGE_RST;
      pos_r <= '0;
      st_r  <= ADR_IDLE;
    end else begin
      din_r <= din_nxt;
      run_r <= run_nxt;
      min_r  <= min_nxt;
      cand_r <= cand_nxt;
      age_r  <= age_nxt;
      pos_r <= pos_nxt;
      st_r  <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // buffer and output stage toward the framer
  // ---------------------------------------------------------------
  // a take while the fifo is full is dropped; in_ready_o shows the stall
  assign fin.valid = take;
  assign fin.data  = serial_i;

  adr_fifo #(.W(FIFO_W), .DEPTH(DEPTH)) u_fifo (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .wr        (fin),
    .rd        (fout)
  );

  logic          vld_r, vld_nxt, dat_r, dat_nxt, rdy_r;
  logic [CW-1:0] mw_r;

  // output register holds one entry; strobe is one cycle per state
  assign fout.ready = framer_ready_i && !vld_r;

  always_comb begin
    vld_nxt = fout.valid && fout.ready;
    dat_nxt = vld_nxt ? fout.data[0] : dat_r;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vld_r <= 1'b0;
      dat_r <= 1'b0;
      rdy_r <= 1'b1;
      mw_r  <= MIN_RST;
    end else begin
      vld_r <= vld_nxt;
      dat_r <= dat_nxt;
      rdy_r <= fin.ready;
      mw_r  <= min_r;
    end
  end

  assign data_valid_o = vld_r;
  assign state_o      = dat_r;
  assign in_ready_o   = rdy_r;
  assign min_width_o  = mw_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_STROBE_ONE : assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    data_valid_o |=> !data_valid_o) else $error("valid strobe longer than one cycle");
  AST_MIN_SHRINK : assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (edge_det && run_r < min_r) |=> min_r == $past(run_r)) else $error("min not updated");
  AST_MIN_TRACK : assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (edge_det && age_r == MIN_AGE_MAX) |=> age_r == AGE_RST) else $error("min not relaxed");
  AST_MID_SAMPLE : assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    take |-> (pos_r == half && !edge_det && st_r == ADR_RUN)) else $error("take off centre");
  AST_ONE_VALUE : assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (fout.valid && fout.ready) |=> (data_valid_o && state_o == $past(fout.data[0])))
    else $error("strobe value mismatch");
  AST_TO_FRAMER : assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !framer_ready_i |=> !data_valid_o) else $error("strobe while framer stalled");
  AST_EDGE_RESYNC : assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (edge_det && st_r == ADR_RUN) |=> pos_r == CNT_ONE) else $error("slot not resynced");
  AST_RUN_AFTER_EDGE : assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    edge_det |=> run_r == CNT_ONE) else $error("width counter not restarted");

  COV_STROBE : cover property (@(posedge ref_clk_i) data_valid_o);
  COV_NEW_MIN : cover property (@(posedge ref_clk_i) edge_det && run_r < min_r);
  COV_FULL : cover property (@(posedge ref_clk_i) !fin.ready);
endmodule : adr_recovery

// file: verif/adr_bmc_src.sv
// biphase-mark serial source standing in for the audio transmitter
module adr_bmc_src (
  // clock
  input  wire logic       ref_clk_i,
  // control
  input  wire logic [7:0] half_w_i,
  input  wire logic       bit_i,
  // line
  output logic            serial_o,
  output logic            half_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_r = 8'h00;
  logic       ph_r  = 1'b0;
  logic       b_r   = 1'b0;
  initial begin
    serial_o = 1'b0;
    half_o   = 1'b0;
  end
  // half width of four or more clocks keeps enough samples per state
  always @(posedge ref_clk_i) begin
    half_o <= (cnt_r == 8'h00);
    if (cnt_r == 8'h00) begin
      cnt_r <= half_w_i - 8'h01;
      ph_r  <= ~ph_r;
      if (!ph_r) b_r <= bit_i;
      // every bit starts with a transition, a one adds one mid-bit
      if (!ph_r || b_r) serial_o <= ~serial_o;
    end else begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule // adr_bmc_src

// file: verif/testbench.sv
// self-checking bench for the state recovery unit
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import adr_pkg::*;
  logic             ref_clk_i      = 1'b0;
  logic             resetn_i       = 1'b0;
  logic             framer_ready_i = 1'b1;
  logic             bit_r          = 1'b0;
  logic             state_o, data_valid_o, in_ready_o, serial, half;
  logic [CNT_W-1:0] min_width_o;
  logic [7:0]       half_w         = 8'h08;
  logic [31:0]      seed           = 32'h5BE2;
  int               bad_count      = 0;
  int               check_count    = 0;
  bit               arm_req = 0, armed = 0, prev_v = 0, rnd_rdy = 0;
  logic             q[$];

  always #25 ref_clk_i = ~ref_clk_i;

  adr_recovery i_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .serial_i(serial),
    .framer_ready_i(framer_ready_i), .state_o(state_o), .data_valid_o(data_valid_o),
    .in_ready_o(in_ready_o), .min_width_o(min_width_o));
  adr_bmc_src i_src (.ref_clk_i(ref_clk_i), .half_w_i(half_w), .bit_i(bit_r),
    .serial_o(serial), .half_o(half));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp_bit(input logic a, input logic e);
    check_count++;
    if (a !== e) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic cmp_w(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] e);
    check_count++;
    if (a !== e) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // bounded wait for n half-bit boundaries of the source
  task automatic halves(input int n);
    int t;
    t = 0;
    while (n > 0) begin
      @(posedge ref_clk_i);
      if (half) n--;
      if (++t > 20000) begin
        bad_count++;
        wrap_up();
      end
    end
  endtask
  task automatic chk_rst();
    cmp_bit(data_valid_o, 1'b0);
    cmp_bit(state_o, 1'b0);
    cmp_bit(in_ready_o, 1'b1);
    cmp_w(min_width_o, MIN_RST);
  endtask

  // ---------------------------------------------------------------
  // model: one expected state per half-bit, level taken at its start
  // ---------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    seed = lfsr(seed);
    bit_r <= seed[0];
    if (rnd_rdy) framer_ready_i <= seed[3] | seed[7];
    if (resetn_i && data_valid_o) begin
      cmp_bit(prev_v, 1'b0);
      if (armed) cmp_bit(state_o, q.size() ? q.pop_front() : ~state_o);
    end
    prev_v = data_valid_o;
    // arming only at a boundary keeps the model aligned to whole states
    if (half) armed = arm_req;
    if (!armed) q.delete();
    else if (half) q.push_back(serial);
  end

  initial begin
    int t;
    repeat (20) @(posedge ref_clk_i);
    chk_rst();
    resetn_i <= 1'b1;
    halves(40);
    arm_req = 1;
    halves(200);
    cmp_w(min_width_o, 8'h08);
    rnd_rdy = 1;
    halves(200);
    rnd_rdy = 0;
    framer_ready_i <= 1'b1;
    halves(10);
    cmp_bit(q.size() <= 1, 1'b1);
    arm_req = 0;
    half_w <= 8'h0C;
    // a slower rate settles within two measurement windows of 256 edges
    halves(900);
    arm_req = 1;
    halves(150);
    cmp_w(min_width_o, 8'h0C);
    arm_req = 0;
    half_w <= 8'h08;
    halves(30);
    arm_req = 1;
    halves(100);
    cmp_w(min_width_o, 8'h08);
    arm_req = 0;
    framer_ready_i <= 1'b0;
    for (t = 0; t < 400 && in_ready_o !== 1'b0; t++) @(posedge ref_clk_i);
    cmp_bit(in_ready_o, 1'b0);
    cmp_bit(data_valid_o, 1'b0);
    framer_ready_i <= 1'b1;
    repeat (40) @(posedge ref_clk_i);
    cmp_bit(in_ready_o, 1'b1);
    // reset must clear outputs without waiting for a clock edge
    @(negedge ref_clk_i);
    resetn_i = 1'b0;
    #1;
    chk_rst();
    repeat (5) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    halves(20);
    wrap_up();
  end
endmodule // testbench
